// File: rtl/cwg_consts.vh
// Constants shared by the complementary waveform generator files
//
// Contract
// - Two output waveforms, primary and complement, are made from the one selected input.
// - Each output's off-to-on edge may be delayed after the other's on-to-off edge.
// - A fault ends active drive at once so that it cannot do damage; the code takes three core clocks, two of them in the synchroniser.
// - One clock-select bit picks the system clock or the 16 MHz internal oscillator.
// - A three-bit field picks comparator, one of four PWM channels, oscillator or logic cell.
// - Right after the module is enabled both drives start cleared.
// - Each output has its own enable, and while it is clear the pin is not controlled.
// - While an output is enabled it shows the override level or the active waveform.
// - While the module enable is clear, output enables and drive levels have no effect.
// - Each output has a polarity bit: set means active-high, clear means active-low.
// - Override levels are never changed by the polarity bits.
// - Dead time is counted by two independent six-bit counters on the module clock.
`ifndef CWG_CONSTS_VH
`define CWG_CONSTS_VH

// ----------------------------------------
// Register bus
// ----------------------------------------
`define CWG_ADDR_W 3
`define CWG_DATA_W 8
`define CWG_ADDR_CON0 3'h0
`define CWG_ADDR_CON1 3'h1
`define CWG_ADDR_DB_RISE 3'h2
`define CWG_ADDR_DB_FALL 3'h3
`define CWG_ADDR_SHUT 3'h4
`define CWG_ADDR_STATUS 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CWG_BIT_EN 7
`define CWG_BIT_OEA 6
`define CWG_BIT_OEB 5
`define CWG_BIT_POLA 4
`define CWG_BIT_POLB 3
`define CWG_BIT_CS 0
`define CWG_BIT_SW_SHUT 0
`define CWG_BIT_SHUT_STATE 1
`define CWG_BIT_OVR_A 2
`define CWG_BIT_OVR_B 3
`define CWG_DB_W 6
`define CWG_IS_W 3
`define CWG_BIT_ACT_A 0
`define CWG_BIT_ACT_B 1
`define CWG_BIT_BUSY_R 2
`define CWG_BIT_BUSY_F 3
`define CWG_BIT_LEVEL 4
`define CWG_BIT_FAULT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CWG_CON0_RST 8'h00
`define CWG_IS_RST 3'h0
`define CWG_DB_RST 6'h00

// ----------------------------------------
// Input source codes
// ----------------------------------------
`define CWG_SRC_CMP 3'h0
`define CWG_SRC_PWM1 3'h1
`define CWG_SRC_PWM2 3'h2
`define CWG_SRC_PWM3 3'h3
`define CWG_SRC_PWM4 3'h4
`define CWG_SRC_NCO 3'h5
`define CWG_SRC_LC 3'h6
`define CWG_NUM_SRC 7

// ----------------------------------------
// Clock rates in MHz, sized to the phase accumulator
// ----------------------------------------
`define CWG_SYS_CLK_MHZ 7'h32
`define CWG_HFOSC_MHZ 7'h10
// One bit of headroom: the sum before wrap reaches 64, which six bits would lose
`define CWG_ACC_W 7

`endif

// File: rtl/cwg_in_sel.v
// Input synchroniser and source selector
`timescale 1ns/1ps
`include "cwg_consts.vh"

module cwg_in_sel #(
  parameter NUM_SRC = `CWG_NUM_SRC
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Sources and selection
  input wire [NUM_SRC-1:0] i_src,
  input wire [`CWG_IS_W-1:0] i_sel,
  // Selected level
  output reg o_level
);

  reg [NUM_SRC-1:0] meta;
  reg [NUM_SRC-1:0] sync;

  // Pick one synced source; the reserved code reads as a quiet low input
  function pick;
    input [NUM_SRC-1:0] src;
    input [`CWG_IS_W-1:0] sel;
    begin
      if (sel < NUM_SRC) begin
        pick = src[sel];
      end else begin
        pick = 1'b0;
      end
    end
  endfunction

  // Two-stage synchroniser per source, since producers may sit on other clocks
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : g_sync
      always @(posedge i_core_clk) begin
        if (i_rst) begin
          meta[g] <= 1'b0;
          sync[g] <= 1'b0;
        end else begin
          meta[g] <= i_src[g];
          sync[g] <= meta[g];
        end
      end
    end
  endgenerate

  // Registered selection
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_level <= 1'b0;
    end else begin
      o_level <= pick(sync, i_sel);
    end
  end

endmodule

// File: rtl/cwg_dead_band.v
// Dead-band delay for one output edge
`timescale 1ns/1ps
`include "cwg_consts.vh"

module cwg_dead_band #(
  parameter CNT_W = `CWG_DB_W
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Control
  input wire i_clear,
  input wire i_tick,
  input wire [CNT_W-1:0] i_delay,
  // Waveform
  input wire i_level,
  output reg o_active,
  output reg o_busy
);

  reg level_d;
  reg [CNT_W-1:0] cnt;

  // Rise is delayed by i_delay module-clock ticks, fall is passed at once
  always @(posedge i_core_clk) begin
    if (i_rst || i_clear) begin
      level_d <= 1'b0;
      cnt <= {CNT_W{1'b0}};
      o_busy <= 1'b0;
      o_active <= 1'b0;
    end else begin
      level_d <= i_level;
      if (!i_level) begin
        o_active <= 1'b0;
        o_busy <= 1'b0;
      end else if (!level_d) begin
        if (i_delay == {CNT_W{1'b0}}) begin
          o_active <= 1'b1;
        end else begin
          cnt <= i_delay;
          o_busy <= 1'b1;
        end
      end else if (o_busy && i_tick) begin
        if (cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          o_active <= 1'b1;
          o_busy <= 1'b0;
        end
        cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// File: rtl/cwg_top.v
// Complementary waveform generator top: registers, clocking, output stage
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`include "cwg_consts.vh"

module cwg_top #(
  parameter DB_W = `CWG_DB_W
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,

  // Register port
  input wire [`CWG_ADDR_W-1:0] i_addr,
  input wire [`CWG_DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [`CWG_DATA_W-1:0] o_rdata,

  // Waveform sources
  input wire i_comparator_sync_out,
  input wire i_pwm_channel1_out,
  input wire i_pwm_channel2_out,
  input wire i_pwm_channel3_out,
  input wire i_pwm_channel4_out,
  input wire i_numeric_osc_out,
  input wire i_logic_cell_out,

  // Fault input, active high
  input wire i_fault,

  // Output pins
  output reg o_primary_drive,
  output reg o_primary_oe,
  output reg o_complement_drive,
  output reg o_complement_oe
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg module_enable;
  reg primary_output_enable;
  reg complement_output_enable;
  reg primary_polarity;
  reg complement_polarity;
  reg clock_source_select;
  reg [`CWG_IS_W-1:0] input_source_select;
  reg [DB_W-1:0] rise_delay;
  reg [DB_W-1:0] fall_delay;
  reg sw_shutdown;
  reg shutdown_state;
  reg override_a;
  reg override_b;

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  wire wr_con0;
  wire wr_con1;
  wire wr_rise;
  wire wr_fall;
  wire wr_shut;
  wire sel_level;
  wire primary_active;
  wire complement_active;
  wire rise_busy;
  wire fall_busy;
  reg enable_d;
  wire enable_start;
  reg fault_meta;
  reg fault_sync;
  reg [`CWG_ACC_W-1:0] acc;
  reg [`CWG_ACC_W-1:0] next_acc;
  reg osc_tick;
  reg next_osc_tick;
  wire tick;
  reg next_shutdown;
  reg [`CWG_DATA_W-1:0] next_rdata;
  reg next_a;
  reg next_b;

  // Address decode shared by all write strobes
  function hit;
    input [`CWG_ADDR_W-1:0] addr;
    input [`CWG_ADDR_W-1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign wr_con0 = i_wr && hit(i_addr, `CWG_ADDR_CON0);
  assign wr_con1 = i_wr && hit(i_addr, `CWG_ADDR_CON1);
  assign wr_rise = i_wr && hit(i_addr, `CWG_ADDR_DB_RISE);
  assign wr_fall = i_wr && hit(i_addr, `CWG_ADDR_DB_FALL);
  assign wr_shut = i_wr && hit(i_addr, `CWG_ADDR_SHUT);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Control word 0: enables, polarities and clock select
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      module_enable <= 1'b0;
      primary_output_enable <= 1'b0;
      complement_output_enable <= 1'b0;
      primary_polarity <= 1'b0;
      complement_polarity <= 1'b0;
      clock_source_select <= 1'b0;
    end else if (wr_con0) begin
      module_enable <= i_wdata[`CWG_BIT_EN];
      primary_output_enable <= i_wdata[`CWG_BIT_OEA];
      complement_output_enable <= i_wdata[`CWG_BIT_OEB];
      primary_polarity <= i_wdata[`CWG_BIT_POLA];
      complement_polarity <= i_wdata[`CWG_BIT_POLB];
      clock_source_select <= i_wdata[`CWG_BIT_CS];
    end
  end

  // Control word 1 and dead-band delays
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      input_source_select <= `CWG_IS_RST;
      rise_delay <= `CWG_DB_RST;
      fall_delay <= `CWG_DB_RST;
    end else begin
      if (wr_con1) begin
        input_source_select <= i_wdata[`CWG_IS_W-1:0];
      end
      if (wr_rise) begin
        rise_delay <= i_wdata[DB_W-1:0];
      end
      if (wr_fall) begin
        fall_delay <= i_wdata[DB_W-1:0];
      end
    end
  end

  // Shutdown control: software request and override levels
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      sw_shutdown <= 1'b0;
      override_a <= 1'b0;
      override_b <= 1'b0;
    end else if (wr_shut) begin
      sw_shutdown <= i_wdata[`CWG_BIT_SW_SHUT];
      override_a <= i_wdata[`CWG_BIT_OVR_A];
      override_b <= i_wdata[`CWG_BIT_OVR_B];
    end
  end

  // ----------------------------------------
  // Fault synchroniser
  // ----------------------------------------
  // Fault source may be asynchronous; only the second stage is looked at
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
    end else begin
      fault_meta <= i_fault;
      fault_sync <= fault_meta;
    end
  end

  // Shutdown state is sticky; a new fault beats a software clear
  always @* begin
    next_shutdown = shutdown_state;
    if (wr_shut && !i_wdata[`CWG_BIT_SHUT_STATE]) begin
      next_shutdown = 1'b0;
    end
    if (fault_sync || sw_shutdown) begin
      next_shutdown = 1'b1;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      shutdown_state <= 1'b0;
    end else begin
      shutdown_state <= next_shutdown;
    end
  end

  // ----------------------------------------
  // Module clock
  // ----------------------------------------
  // The oscillator rate is made as a fractional tick from the core clock,
  // so the whole block stays in one domain; jitter is one core period
  always @* begin
    next_acc = acc + `CWG_HFOSC_MHZ;
    next_osc_tick = 1'b0;
    if (next_acc >= `CWG_SYS_CLK_MHZ) begin
      next_acc = next_acc - `CWG_SYS_CLK_MHZ;
      next_osc_tick = 1'b1;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      acc <= {`CWG_ACC_W{1'b0}};
      osc_tick <= 1'b0;
    end else begin
      acc <= next_acc;
      osc_tick <= next_osc_tick;
    end
  end

  // Clear picks the system clock, set picks the oscillator
  assign tick = clock_source_select ? osc_tick : 1'b1;

  // ----------------------------------------
  // Waveform path
  // ----------------------------------------
  cwg_in_sel #(
    .NUM_SRC(`CWG_NUM_SRC)
  ) u_in_sel (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_src({i_logic_cell_out, i_numeric_osc_out, i_pwm_channel4_out,
            i_pwm_channel3_out, i_pwm_channel2_out, i_pwm_channel1_out,
            i_comparator_sync_out}),
    .i_sel(input_source_select),
    .o_level(sel_level)
  );

  // Enable edge, used to restart both drives cleared
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      enable_d <= 1'b0;
    end else begin
      enable_d <= module_enable;
    end
  end

  assign enable_start = module_enable && !enable_d;

  // Primary follows the input, delayed on its rising edge
  cwg_dead_band #(
    .CNT_W(DB_W)
  ) u_db_rise (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(!module_enable || enable_start || shutdown_state),
    .i_tick(tick),
    .i_delay(rise_delay),
    .i_level(sel_level),
    .o_active(primary_active),
    .o_busy(rise_busy)
  );

  // Complement follows the inverted input, delayed on the falling edge
  cwg_dead_band #(
    .CNT_W(DB_W)
  ) u_db_fall (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_clear(!module_enable || enable_start || shutdown_state),
    .i_tick(tick),
    .i_delay(fall_delay),
    .i_level(!sel_level),
    .o_active(complement_active),
    .o_busy(fall_busy)
  );

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  // Shutdown shows override levels unchanged; otherwise the active level
  // is mapped through polarity, where clear polarity means active-low
  always @* begin
    if (shutdown_state || next_shutdown) begin
      next_a = override_a;
      next_b = override_b;
    end else begin
      next_a = primary_polarity ? primary_active : !primary_active;
      next_b = complement_polarity ? complement_active : !complement_active;
    end
  end

  // Pins are only driven while both module and output enables are set
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_primary_drive <= 1'b0;
      o_complement_drive <= 1'b0;
      o_primary_oe <= 1'b0;
      o_complement_oe <= 1'b0;
    end else begin
      o_primary_oe <= module_enable && primary_output_enable;
      o_complement_oe <= module_enable && complement_output_enable;
      o_primary_drive <= module_enable ? next_a : 1'b0;
      o_complement_drive <= module_enable ? next_b : 1'b0;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped addresses read zero; read data stands for one cycle only
  always @* begin
    next_rdata = {`CWG_DATA_W{1'b0}};
    case (i_addr)
      `CWG_ADDR_CON0: begin
        next_rdata[`CWG_BIT_EN] = module_enable;
        next_rdata[`CWG_BIT_OEA] = primary_output_enable;
        next_rdata[`CWG_BIT_OEB] = complement_output_enable;
        next_rdata[`CWG_BIT_POLA] = primary_polarity;
        next_rdata[`CWG_BIT_POLB] = complement_polarity;
        next_rdata[`CWG_BIT_CS] = clock_source_select;
      end
      `CWG_ADDR_CON1: begin
        next_rdata[`CWG_IS_W-1:0] = input_source_select;
      end
      `CWG_ADDR_DB_RISE: begin
        next_rdata[DB_W-1:0] = rise_delay;
      end
      `CWG_ADDR_DB_FALL: begin
        next_rdata[DB_W-1:0] = fall_delay;
      end
      `CWG_ADDR_SHUT: begin
        next_rdata[`CWG_BIT_SW_SHUT] = sw_shutdown;
        next_rdata[`CWG_BIT_SHUT_STATE] = shutdown_state;
        next_rdata[`CWG_BIT_OVR_A] = override_a;
        next_rdata[`CWG_BIT_OVR_B] = override_b;
      end
      `CWG_ADDR_STATUS: begin
        next_rdata[`CWG_BIT_ACT_A] = primary_active;
        next_rdata[`CWG_BIT_ACT_B] = complement_active;
        next_rdata[`CWG_BIT_BUSY_R] = rise_busy;
        next_rdata[`CWG_BIT_BUSY_F] = fall_busy;
        next_rdata[`CWG_BIT_LEVEL] = sel_level;
        next_rdata[`CWG_BIT_FAULT] = fault_sync;
      end
      default: begin
        next_rdata = {`CWG_DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rdata <= {`CWG_DATA_W{1'b0}};
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= {`CWG_DATA_W{1'b0}};
    end
  end

endmodule

// File: tb/cwg_src_model.sv
// Model of the on-chip peripherals that feed the waveform sources
`timescale 1ns/1ps
module cwg_src_model (
  // Clock
  input wire i_core_clk,
  // Requested levels, bit 0 comparator up to bit 6 logic cell
  input wire [6:0] i_level,
  // Peripheral outputs
  output reg o_cmp = 1'b0,
  output reg o_pwm1 = 1'b0,
  output reg o_pwm2 = 1'b0,
  output reg o_pwm3 = 1'b0,
  output reg o_pwm4 = 1'b0,
  output reg o_osc = 1'b0,
  output reg o_lc = 1'b0
);
  // Peripherals are clocked logic, so their outputs only move just after an edge
  always @(posedge i_core_clk) begin
    o_cmp <= i_level[0];
    o_pwm1 <= i_level[1];
    o_pwm2 <= i_level[2];
    o_pwm3 <= i_level[3];
    o_pwm4 <= i_level[4];
    o_osc <= i_level[5];
    o_lc <= i_level[6];
  end
endmodule

// File: tb/cwg_top_asserts.sv
// Assertion checker for the waveform generator top
`timescale 1ns/1ps
module cwg_top_asserts (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Register port
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  // Fault and pins
  input wire i_fault,
  input wire o_primary_drive,
  input wire o_primary_oe,
  input wire o_complement_drive,
  input wire o_complement_oe
);
  reg [7:0] con0_q;
  reg sw_q;
  reg ova;
  reg ovb;
  reg sd_seen;
  wire en = con0_q[7];

  // Shadow of control writes; sticky flag hides the start and overlap checks after a shutdown
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      con0_q <= 8'h00;
      sw_q <= 1'b0;
      ova <= 1'b0;
      ovb <= 1'b0;
      sd_seen <= 1'b0;
    end else begin
      if (i_wr && i_addr == 3'h0) con0_q <= i_wdata;
      if (i_wr && i_addr == 3'h4) begin
        sw_q <= i_wdata[0];
        ova <= i_wdata[2];
        ovb <= i_wdata[3];
      end
      if (i_fault || sw_q) sd_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_sw_held;
    (en && sw_q) [*4];
  endsequence
  sequence s_fault_held;
    (en && i_fault) [*5];
  endsequence

  property p_rdata_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  property p_unmapped;
    i_rd && i_addr[2:1] == 2'h3 |=> o_rdata == 8'h00;
  endproperty
  property p_oe_a;
    $stable(con0_q) |-> o_primary_oe == (con0_q[7] & con0_q[6]);
  endproperty
  property p_oe_b;
    $stable(con0_q) |-> o_complement_oe == (con0_q[7] & con0_q[5]);
  endproperty
  property p_disabled;
    $stable(con0_q) && !en |-> !o_primary_drive && !o_complement_drive;
  endproperty
  property p_start_clear;
    $rose(en) && !sd_seen |=> o_primary_drive == !con0_q[4] && o_complement_drive == !con0_q[3];
  endproperty
  property p_no_overlap;
    en && !sd_seen && $stable(con0_q)
      |-> !(o_primary_drive == con0_q[4] && o_complement_drive == con0_q[3]);
  endproperty
  property p_sw_override;
    s_sw_held |-> o_primary_drive == ova && o_complement_drive == ovb;
  endproperty
  property p_fault_override;
    s_fault_held |-> o_primary_drive == ova && o_complement_drive == ovb;
  endproperty

  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_oe_a: assert property (p_oe_a)
    else $error("primary enable wrong");
  a_oe_b: assert property (p_oe_b)
    else $error("complement enable wrong");
  a_disabled: assert property (p_disabled)
    else $error("drive while disabled");
  a_start_clear: assert property (p_start_clear)
    else $error("drives not cleared at enable");
  a_no_overlap: assert property (p_no_overlap)
    else $error("both outputs active");
  a_sw_override: assert property (p_sw_override)
    else $error("override level wrong");
  a_fault_override: assert property (p_fault_override)
    else $error("fault did not end drive");
endmodule

bind cwg_top cwg_top_asserts i_cwg_top_asserts (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_fault(i_fault),
  .o_primary_drive(o_primary_drive),
  .o_primary_oe(o_primary_oe),
  .o_complement_drive(o_complement_drive),
  .o_complement_oe(o_complement_oe)
);

// File: tb/cwg_top_tb.sv
// Self-checking testbench for the waveform generator top
`timescale 1ns/1ps
module cwg_top_tb;
  reg i_core_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [2:0] i_addr = 3'h0;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_fault = 1'b0;
  reg [6:0] lvl = 7'h00;
  wire [7:0] o_rdata;
  wire [6:0] s;
  wire pa;
  wire ca;
  wire poe;
  wire coe;
  integer fails = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  integer n;
  integer g;
  reg [7:0] d;

  cwg_src_model i_cwg_src_model (.i_core_clk(i_core_clk), .i_level(lvl), .o_cmp(s[0]),
    .o_pwm1(s[1]), .o_pwm2(s[2]), .o_pwm3(s[3]), .o_pwm4(s[4]), .o_osc(s[5]), .o_lc(s[6]));
  cwg_top i_cwg_top (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_comparator_sync_out(s[0]), .i_pwm_channel1_out(s[1]), .i_pwm_channel2_out(s[2]),
    .i_pwm_channel3_out(s[3]), .i_pwm_channel4_out(s[4]), .i_numeric_osc_out(s[5]),
    .i_logic_cell_out(s[6]), .i_fault(i_fault), .o_primary_drive(pa),
    .o_primary_oe(poe), .o_complement_drive(ca), .o_complement_oe(coe));

  // 50 MHz clock
  initial begin
    forever #10 i_core_clk = ~i_core_clk;
  end

  // ----
  // Tasks
  // ----
  task report_and_stop;
    begin
      if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] v);
    begin
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, output [7:0] v);
    begin
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
    end
  endtask
  task wt(input integer k);
    begin
      repeat (k) @(posedge i_core_clk);
      #1;
    end
  endtask
  // Cycles from one output leaving active to the other becoming active
  task gap(input fs, output integer gv);
    begin
      n = 0;
      while ((fs ? pa : ca) !== 1'b0 && n < 300) begin
        wt(1);
        n = n + 1;
      end
      gv = 0;
      while ((fs ? ca : pa) !== 1'b1 && gv < 300) begin
        wt(1);
        gv = gv + 1;
      end
    end
  endtask

  // Hang guard, far above the roughly 450 cycles the tests need
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end

  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (i != 5) rd(i[2:0], d);
      if (i != 5) chk("reset", d, 8'h00);
    end
    wr(3'h6, 8'hFF);
    rd(3'h6, d);
    chk("unmapped", d, 8'h00);
    // Every source code, with the chosen line alone high and then alone low
    for (i = 0; i < 8; i = i + 1) begin
      wr(3'h1, i[7:0]);
      lvl <= 7'h01 << i;
      wt(6);
      rd(3'h5, d);
      chk("sel_hi", d[4], i < 7);
      lvl <= ~(7'h01 << i);
      wt(6);
      rd(3'h5, d);
      chk("sel_lo", d[4], 1'b0);
    end
    wr(3'h1, 8'h00);
    lvl <= 7'h00;
    wt(6);
    wr(3'h0, 8'hF8);
    wt(1);
    chk("enable", {poe, coe, pa, ca}, 8'h0C);
    wt(8);
    chk("low_src", {pa, ca}, 8'h01);
    // Dead band on both edges, rise at the longest and shortest nonzero counts, fall at 7
    wr(3'h2, 8'h3F);
    wr(3'h3, 8'h07);
    lvl <= 7'h01;
    gap(1'b0, g);
    chk("rise63", g, 8'd63);
    lvl <= 7'h00;
    gap(1'b1, g);
    chk("fall7", g, 8'd7);
    wr(3'h2, 8'h01);
    lvl <= 7'h01;
    gap(1'b0, g);
    chk("rise1", g, 8'd1);
    // Oscillator ticks stretch each count by about 50/16
    wr(3'h0, 8'hF9);
    wr(3'h2, 8'h10);
    lvl <= 7'h00;
    wt(40);
    lvl <= 7'h01;
    gap(1'b0, g);
    chk("osc_rise", g >= 46 && g <= 54, 1'b1);
    wr(3'h0, 8'hF8);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'hE0);
    wt(8);
    chk("pol_low", {pa, ca}, 8'h01);
    rd(3'h5, d);
    chk("status", d, 8'h11);
    // Software shutdown: overrides must not follow the polarity
    wr(3'h4, 8'h05);
    wt(4);
    chk("sw_ovr", {pa, ca}, 8'h02);
    rd(3'h4, d);
    chk("sd_state", d, 8'h07);
    wr(3'h4, 8'h04);
    wr(3'h4, 8'h04);
    wt(6);
    chk("resume", {pa, ca}, 8'h01);
    @(posedge i_core_clk) i_fault <= 1'b1;
    wt(6);
    chk("fault_ovr", {pa, ca}, 8'h02);
    rd(3'h4, d);
    chk("fault_st", d, 8'h06);
    @(posedge i_core_clk) i_fault <= 1'b0;
    wt(4);
    wr(3'h4, 8'h04);
    rd(3'h4, d);
    chk("cleared", d, 8'h04);
    wr(3'h0, 8'hD8);
    wt(1);
    chk("oe_split", {poe, coe}, 8'h02);
    wr(3'h0, 8'h78);
    wt(2);
    chk("off", {poe, coe, pa, ca}, 8'h00);
    @(posedge i_core_clk) i_rst <= 1'b1;
    wt(3);
    @(posedge i_core_clk) i_rst <= 1'b0;
    rd(3'h0, d);
    chk("rereset", d, 8'h00);
    report_and_stop;
  end
endmodule
